// file: core/macsec_out_pkg.sv
// Shared constants and types for the MACsec output formatting and classification block.
package macsec_out_pkg;

  // ==========================================================================
  // Widths
  localparam int CORE_W      = 128;
  localparam int LINK_W      = 64;
  localparam int CORE_BYTES  = 16;
  localparam int LINK_BYTES  = 8;
  localparam int CODE_W      = 32;

  // ==========================================================================
  // Frame field lengths in bytes
  localparam logic [7:0] ADDR_BYTES   = 8'h0c;
  localparam logic [7:0] TAG_BYTES    = 8'h04;
  localparam logic [7:0] LABEL_BYTES  = 8'h04;
  localparam logic [7:0] ETYPE_BYTES  = 8'h02;
  localparam logic [7:0] SECTAG_BYTES = 8'h10;

  // ==========================================================================
  // Classification field select bits
  localparam int SEL_W      = 9;
  localparam int F_DA       = 0;
  localparam int F_SA       = 1;
  localparam int F_TAG1     = 2;
  localparam int F_TAG2     = 3;
  localparam int F_ETYPE    = 4;
  localparam int F_MPLS_ET  = 5;
  localparam int F_LABEL1   = 6;
  localparam int F_LABEL2   = 7;
  localparam int F_SECTAG   = 8;

  localparam int SA_COUNT   = 16;
  localparam int SA_IDX_W   = 4;

  // ==========================================================================
  // Frame format, bypass modes and key lengths
  typedef enum logic [2:0] {
    FMT_UNTAGGED = 3'h0,
    FMT_ONE_TAG  = 3'h1,
    FMT_TWO_TAG  = 3'h2,
    FMT_MPLS_ONE = 3'h3,
    FMT_MPLS_TWO = 3'h4
  } format_t;

  typedef enum logic [1:0] {
    BYP_NONE  = 2'h0,
    BYP_ONE   = 2'h1,
    BYP_TWO   = 2'h2,
    BYP_MPLS  = 2'h3
  } bypass_t;

  typedef enum logic {
    KEY_128 = 1'b0,
    KEY_256 = 1'b1
  } key_len_t;

  // ==========================================================================
  // Width converter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } conv_state_t;

endpackage

// file: core/output_width_converter.sv
// Converter from the 128-bit core word stream to the 64-bit link word stream.
`timescale 1ns/10ps
module output_width_converter
  import macsec_out_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  in_valid_i,
  output logic                       in_ready_o,
  input  wire logic [CORE_W-1:0]     in_data_i,
  input  wire logic                  in_sof_i,
  input  wire logic                  in_eof_i,
  input  wire logic [4:0]            in_bytes_i,
  input  wire logic                  in_fail_i,
  input  wire logic [CODE_W-1:0]     in_code_i,
  output logic                       out_valid_o,
  input  wire logic                  out_ready_i,
  output logic [LINK_W-1:0]          out_data_o,
  output logic                       out_sof_o,
  output logic                       out_eof_o,
  output logic [3:0]                 out_bytes_o
);

  // ==========================================================================
  // Word holding and lane selection
  logic [CORE_W-1:0] word;
  logic              sof;
  logic              eof;
  logic [4:0]        nbytes;
  logic              fail;
  logic [CODE_W-1:0] code;
  conv_state_t       state;
  conv_state_t       next_state;
  logic [LINK_W-1:0] lane;
  logic [LINK_W-1:0] next_lane;
  logic              last_low;
  logic [3:0]        lane_bytes;
  logic              lane_last;
  logic              lane_first;
  logic              take;
  logic              give;

  assign last_low   = eof && (nbytes <= 5'(LINK_BYTES));
  assign lane       = (state == ST_HIGH) ? word[CORE_W-1:LINK_W] : word[LINK_W-1:0];
  assign lane_last  = (state == ST_HIGH) ? eof : last_low;
  assign lane_first = (state == ST_LOW) && sof;
  assign lane_bytes = !lane_last ? 4'h8 :
                      (state == ST_HIGH) ? 4'(nbytes - 5'(LINK_BYTES)) : nbytes[3:0];
  assign give       = (state != ST_IDLE) && (!out_valid_o || out_ready_i);
  assign take       = in_valid_i && in_ready_o;
  assign in_ready_o = (state == ST_IDLE) || (give && ((state == ST_HIGH) || last_low));  // R2

  // When the last link word of a failed frame holds four or more valid bytes, its last four carry the debug code.
  always_comb begin
    next_lane = lane;
    if (lane_last && fail) begin  // R3
      case (lane_bytes)
        4'h4:    next_lane[31:0]  = code;
        4'h5:    next_lane[39:8]  = code;
        4'h6:    next_lane[47:16] = code;
        4'h7:    next_lane[55:24] = code;
        4'h8:    next_lane[63:32] = code;
        default: next_lane        = lane;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (take) next_state = ST_LOW;
      ST_LOW:  if (give) next_state = last_low ? (take ? ST_LOW : ST_IDLE) : ST_HIGH;  // R2
      ST_HIGH: if (give) next_state = take ? ST_LOW : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      word  <= '0;
      sof   <= 1'b0;
      eof   <= 1'b0;
      nbytes <= '0;
      fail  <= 1'b0;
      code  <= '0;
    end else begin
      state <= next_state;
      if (take) begin
        word   <= in_data_i;
        sof    <= in_sof_i;
        eof    <= in_eof_i;
        nbytes <= in_bytes_i;
        fail   <= in_fail_i;
        code   <= in_code_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      out_sof_o   <= 1'b0;
      out_eof_o   <= 1'b0;
      out_bytes_o <= '0;
    end else if (give) begin
      out_valid_o <= 1'b1;
      out_data_o  <= next_lane;  // R2
      out_sof_o   <= lane_first;  // R17
      out_eof_o   <= lane_last;  // R17
      out_bytes_o <= lane_bytes;  // R17
    end else if (out_ready_i) begin
      out_valid_o <= 1'b0;
    end
  end

endmodule // output_width_converter

// file: core/macsec_output_format_classify.sv
// Output stage of the MACsec pipeline with frame format and classification field selection.
`timescale 1ns/10ps

// Summary of operation
// R1 - The output stage isolates the core so the output interface always follows its handshake.
// R2 - Each 128-bit core word becomes two 64-bit link words, or one for an end word of up to 8 bytes, low bytes first, frames kept whole.
// R3 - A frame failing its security check has its FCS replaced by the debug code when its last link word holds four or more bytes.
// R4 - Both 128-bit and 256-bit key lengths are accepted and reported for each frame.
// R5 - With bypass, tags or labels stay clear outside the protected region.
// R6 - Without bypass, tags and labels sit after the security tag and are encrypted.
// R7 - The classification field set is chosen separately for every secure association.
// R8 - With zero offset, receive classification uses no field after the security tag.
// R9 - Standard transmit uses addresses, tags and Ethertype; receive uses addresses and tag.
// R10 - Single-tag bypass of one tag puts the security tag after it and classifies on it.
// R11 - Single-tag bypass of two tags keeps only the outer tag clear before the security tag.
// R12 - Dual-tag bypass keeps both tags clear before the security tag and classifies on both.
// R13 - One-label transmit classification uses client addresses, MPLS Ethertype and the label.
// R14 - MPLS bypass puts the security tag after the labels and receive uses them plus the tag.
// R15 - Two-label frames classify on both labels in transmit, and in receive with MPLS bypass.
// R16 - The check value follows the payload before the FCS and covers all but bypassed fields.
// R17 - Link words mark first, last and valid bytes, and one word moves per cycle with valid and ready both high.
module macsec_output_format_classify
  import macsec_out_pkg::*;
(
  input  wire logic                  MCLK_I,
  input  wire logic                  RESET_N_I,
  input  wire logic                  CORE_VALID_I,
  output logic                       CORE_READY_O,
  input  wire logic [CORE_W-1:0]     CORE_DATA_I,
  input  wire logic                  CORE_SOF_I,
  input  wire logic                  CORE_EOF_I,
  input  wire logic [4:0]            CORE_BYTES_I,
  input  wire logic                  CORE_SEC_FAIL_I,
  input  wire logic [CODE_W-1:0]     CORE_DEBUG_CODE_I,
  output logic                       LINK_VALID_O,
  input  wire logic                  LINK_READY_I,
  output logic [LINK_W-1:0]          LINK_DATA_O,
  output logic                       LINK_SOF_O,
  output logic                       LINK_EOF_O,
  output logic [3:0]                 LINK_BYTES_O,
  input  wire logic                  CFG_WRITE_I,
  input  wire logic [SA_IDX_W-1:0]   CFG_SA_I,
  input  wire logic [2:0]            CFG_FORMAT_I,
  input  wire logic [1:0]            CFG_BYPASS_I,
  input  wire logic                  CFG_KEY_256_I,
  input  wire logic [SEL_W-1:0]      CFG_FIELD_MASK_I,
  input  wire logic [SA_IDX_W-1:0]   LOOKUP_SA_I,
  input  wire logic                  LOOKUP_RX_I,
  output logic [SEL_W-1:0]           CLASS_FIELDS_O,
  output logic [7:0]                 SECTAG_OFFSET_O,
  output logic [7:0]                 CLEAR_BYTES_O,
  output logic                       KEY_256_O
);

  // ==========================================================================
  // Core side adapter
  logic in_valid;
  logic in_ready;
  logic in_start_ok;
  logic in_frame;

  // A frame may only start at a start word and continues until its end word.
  assign in_start_ok  = in_frame || CORE_SOF_I;
  assign in_valid     = CORE_VALID_I && in_start_ok;  // R1
  assign CORE_READY_O = in_ready || (CORE_VALID_I && !in_start_ok);  // R1

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      in_frame <= 1'b0;
    end else if (in_valid && in_ready) begin
      in_frame <= !CORE_EOF_I;  // R1
    end
  end

  // ==========================================================================
  // Width conversion
  output_width_converter u_conv (
    .clk_i       (MCLK_I),
    .rst_n_i     (RESET_N_I),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .in_data_i   (CORE_DATA_I),
    .in_sof_i    (CORE_SOF_I),
    .in_eof_i    (CORE_EOF_I),
    .in_bytes_i  (CORE_BYTES_I),
    .in_fail_i   (CORE_SEC_FAIL_I),
    .in_code_i   (CORE_DEBUG_CODE_I),
    .out_valid_o (LINK_VALID_O),
    .out_ready_i (LINK_READY_I),
    .out_data_o  (LINK_DATA_O),
    .out_sof_o   (LINK_SOF_O),
    .out_eof_o   (LINK_EOF_O),
    .out_bytes_o (LINK_BYTES_O)
  );

  // ==========================================================================
  // Per-SA configuration table
  logic [2:0]       sa_format [SA_COUNT];
  logic [1:0]       sa_bypass [SA_COUNT];
  logic             sa_key    [SA_COUNT];
  logic [SEL_W-1:0] sa_mask   [SA_COUNT];

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      for (int i = 0; i < SA_COUNT; i++) begin
        sa_format[i] <= FMT_UNTAGGED;
        sa_bypass[i] <= BYP_NONE;
        sa_key[i]    <= KEY_128;
        sa_mask[i]   <= '1;
      end
    end else if (CFG_WRITE_I) begin
      sa_format[CFG_SA_I] <= CFG_FORMAT_I;
      sa_bypass[CFG_SA_I] <= CFG_BYPASS_I;
      sa_key[CFG_SA_I]    <= CFG_KEY_256_I;  // R4
      sa_mask[CFG_SA_I]   <= CFG_FIELD_MASK_I;  // R7
    end
  end

  // ==========================================================================
  // Frame layout and classifiable fields
  format_t          fmt;
  bypass_t          byp;
  logic [SEL_W-1:0] tx_fields;
  logic [SEL_W-1:0] rx_fields;
  logic [SEL_W-1:0] avail;
  logic [7:0]       clear_bytes;
  logic             two_tags;
  logic             mpls;

  assign fmt      = format_t'(sa_format[LOOKUP_SA_I]);
  assign byp      = bypass_t'(sa_bypass[LOOKUP_SA_I]);
  assign two_tags = (fmt == FMT_TWO_TAG);
  assign mpls     = (fmt == FMT_MPLS_ONE) || (fmt == FMT_MPLS_TWO);

  // Transmit sees the whole clear frame before encryption.
  always_comb begin
    tx_fields = '0;
    tx_fields[F_DA] = 1'b1;  // R9
    tx_fields[F_SA] = 1'b1;
    case (fmt)
      FMT_UNTAGGED: tx_fields[F_ETYPE] = 1'b1;
      FMT_ONE_TAG: begin
        tx_fields[F_TAG1]  = 1'b1;
        tx_fields[F_ETYPE] = 1'b1;
      end
      FMT_TWO_TAG: begin
        tx_fields[F_TAG1]  = 1'b1;
        tx_fields[F_TAG2]  = 1'b1;
        tx_fields[F_ETYPE] = 1'b1;
      end
      FMT_MPLS_ONE: begin
        tx_fields[F_MPLS_ET] = 1'b1;  // R13
        tx_fields[F_LABEL1]  = 1'b1;
      end
      FMT_MPLS_TWO: begin
        tx_fields[F_MPLS_ET] = 1'b1;  // R15
        tx_fields[F_LABEL1]  = 1'b1;
        tx_fields[F_LABEL2]  = 1'b1;
      end
      default: tx_fields[F_ETYPE] = 1'b1;
    endcase
  end

  // Receive sees only what lies up to the security tag; the rest is encrypted.
  always_comb begin
    rx_fields = '0;
    rx_fields[F_DA]     = 1'b1;
    rx_fields[F_SA]     = 1'b1;
    rx_fields[F_SECTAG] = 1'b1;  // R8
    clear_bytes = '0;
    case (byp)
      BYP_NONE: clear_bytes = '0;  // R6 R9
      BYP_ONE: begin
        if (fmt == FMT_ONE_TAG || two_tags) begin
          rx_fields[F_TAG1] = 1'b1;  // R10 R11
          clear_bytes       = TAG_BYTES;  // R5
        end
      end
      BYP_TWO: begin
        if (two_tags) begin
          rx_fields[F_TAG1] = 1'b1;  // R12
          rx_fields[F_TAG2] = 1'b1;
          clear_bytes       = 8'(TAG_BYTES + TAG_BYTES);
        end else if (fmt == FMT_ONE_TAG) begin
          rx_fields[F_TAG1] = 1'b1;
          clear_bytes       = TAG_BYTES;
        end
      end
      BYP_MPLS: begin
        if (mpls) begin
          rx_fields[F_MPLS_ET] = 1'b1;  // R14
          rx_fields[F_LABEL1]  = 1'b1;
          clear_bytes          = 8'(ETYPE_BYTES + LABEL_BYTES);
          if (fmt == FMT_MPLS_TWO) begin
            rx_fields[F_LABEL2] = 1'b1;  // R15
            clear_bytes         = 8'(ETYPE_BYTES + LABEL_BYTES + LABEL_BYTES);
          end
        end
      end
      default: clear_bytes = '0;
    endcase
  end

  assign avail = LOOKUP_RX_I ? rx_fields : tx_fields;

  // ==========================================================================
  // Registered lookup answer
  // The check value is placed after the payload by the core; the span it
  // covers starts at the addresses and skips the clear bytes reported here.
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      CLASS_FIELDS_O  <= '0;
      SECTAG_OFFSET_O <= '0;
      CLEAR_BYTES_O   <= '0;
      KEY_256_O       <= 1'b0;
    end else begin
      CLASS_FIELDS_O  <= avail & sa_mask[LOOKUP_SA_I];  // R7
      SECTAG_OFFSET_O <= 8'(ADDR_BYTES + clear_bytes);  // R5 R10 R11 R12 R14
      CLEAR_BYTES_O   <= clear_bytes;  // R16
      KEY_256_O       <= sa_key[LOOKUP_SA_I];  // R4
    end
  end

endmodule // macsec_output_format_classify

// file: verification/macsec_out_chk.sv
// Port checker of the MACsec output stage.
`timescale 1ns/10ps
module macsec_out_chk
  import macsec_out_pkg::*;
(
  input  wire logic              MCLK_I,
  input  wire logic              RESET_N_I,
  input  wire logic              CORE_VALID_I,
  input  wire logic              CORE_READY_O,
  input  wire logic [CORE_W-1:0] CORE_DATA_I,
  input  wire logic              CORE_SOF_I,
  input  wire logic              CORE_EOF_I,
  input  wire logic              LINK_VALID_O,
  input  wire logic              LINK_READY_I,
  input  wire logic [LINK_W-1:0] LINK_DATA_O,
  input  wire logic              LINK_SOF_O,
  input  wire logic              LINK_EOF_O,
  input  wire logic [3:0]        LINK_BYTES_O,
  input  wire logic              LOOKUP_RX_I,
  input  wire logic [SEL_W-1:0]  CLASS_FIELDS_O,
  input  wire logic [7:0]        SECTAG_OFFSET_O,
  input  wire logic [7:0]        CLEAR_BYTES_O
);
  // ==========================================================================
  // Stream properties.
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_take_first;
    CORE_VALID_I && CORE_READY_O && CORE_SOF_I && !CORE_EOF_I;
  endsequence
  sequence s_low_out;
    LINK_VALID_O && LINK_SOF_O && !LINK_EOF_O && LINK_BYTES_O == 4'h8;
  endsequence
  property p_split;
    s_take_first ##1 !LINK_VALID_O |=> s_low_out ##0
      (LINK_DATA_O == $past(CORE_DATA_I[63:0], 2));
  endproperty
  property p_hold;
    LINK_VALID_O && !LINK_READY_I |=> LINK_VALID_O &&
      $stable({LINK_DATA_O, LINK_SOF_O, LINK_EOF_O, LINK_BYTES_O});
  endproperty
  property p_mid_bytes;
    LINK_VALID_O && !LINK_EOF_O |-> LINK_BYTES_O == 4'h8;
  endproperty
  property p_last_bytes;
    LINK_VALID_O && LINK_EOF_O |-> LINK_BYTES_O inside {[4'h1:4'h8]};
  endproperty
  property p_rst;
    disable iff (1'b0) !RESET_N_I |=> !LINK_VALID_O && CLASS_FIELDS_O == 9'h000;
  endproperty
  a_split: assert property (p_split) else $error("first link word wrong");
  a_hold: assert property (p_hold) else $error("link word changed in stall");
  a_mid_bytes: assert property (p_mid_bytes) else $error("bad mid byte count");
  a_last_bytes: assert property (p_last_bytes) else $error("bad last byte count");
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  // ==========================================================================
  // Lookup properties.
  property p_offset;
    RESET_N_I && $past(RESET_N_I) |-> SECTAG_OFFSET_O == CLEAR_BYTES_O + 8'h0c;
  endproperty
  property p_clear;
    CLEAR_BYTES_O inside {8'h00, 8'h04, 8'h06, 8'h08, 8'h0a};
  endproperty
  property p_rx;
    RESET_N_I && $past(RESET_N_I) && $past(LOOKUP_RX_I) && CLEAR_BYTES_O == 8'h00
      |-> (CLASS_FIELDS_O & 9'h0fc) == 9'h000;
  endproperty
  property p_tx;
    RESET_N_I && $past(RESET_N_I) && !$past(LOOKUP_RX_I) |-> !CLASS_FIELDS_O[F_SECTAG];
  endproperty
  a_offset: assert property (p_offset) else $error("tag offset wrong");
  a_clear: assert property (p_clear) else $error("clear byte count wrong");
  a_rx: assert property (p_rx) else $error("receive field after tag");
  a_tx: assert property (p_tx) else $error("transmit uses tag");
endmodule // macsec_out_chk

// file: verification/link_mac_model.sv
// Behavioural link MAC that takes words from the output stage.
`timescale 1ns/10ps
module link_mac_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic valid_i,
  input  wire logic slow_i,
  output logic      ready_o
);
  // Ready stays high, or alternates while a word is offered so that stalls occur.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= slow_i ? (valid_i & ~ready_o) : 1'b1;
    end
  end
endmodule // link_mac_model

// file: verification/macsec_output_format_classify_tb_top.sv
// Self-checking testbench of the MACsec output stage.
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module macsec_output_format_classify_tb_top
  import macsec_out_pkg::*;
;
  logic              mclk = 1'b0;
  logic              reset_n = 1'b0;
  logic              core_valid = 1'b0;
  logic              core_ready;
  logic [CORE_W-1:0] core_data = '0;
  logic              core_sof = 1'b0;
  logic              core_eof = 1'b0;
  logic              core_fail = 1'b0;
  logic [4:0]        core_bytes = 5'h10;
  logic [CODE_W-1:0] code = 32'hc3d2e1f0;
  logic              link_valid, link_ready, link_sof, link_eof, key_o;
  logic [LINK_W-1:0] link_data;
  logic [3:0]        link_bytes;
  logic              slow = 1'b0;
  logic              cfg_wr = 1'b0;
  logic              key = 1'b0;
  logic              rx = 1'b0;
  logic              taken = 1'b0;
  logic [SA_IDX_W-1:0] cfg_sa = '0;
  logic [SA_IDX_W-1:0] lk_sa = '0;
  logic [2:0]        fmt = '0;
  logic [1:0]        byp = '0;
  logic [SEL_W-1:0]  mask = '1;
  logic [SEL_W-1:0]  fields;
  logic [7:0]        offset, clear;
  logic [69:0]       seen[$];
  int                fails = 0;
  int                compares = 0;
  // ==========================================================================
  // Clock, monitors and instances.
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) taken <= core_valid & core_ready;
  always @(posedge mclk) if (link_valid && link_ready) seen.push_back({link_sof, link_eof,
    link_bytes, link_data});
  macsec_output_format_classify macsec_output_format_classify_i (
    .MCLK_I(mclk), .RESET_N_I(reset_n), .CORE_VALID_I(core_valid), .CORE_READY_O(core_ready),
    .CORE_DATA_I(core_data), .CORE_SOF_I(core_sof), .CORE_EOF_I(core_eof),
    .CORE_BYTES_I(core_bytes), .CORE_SEC_FAIL_I(core_fail), .CORE_DEBUG_CODE_I(code),
    .LINK_VALID_O(link_valid), .LINK_READY_I(link_ready), .LINK_DATA_O(link_data),
    .LINK_SOF_O(link_sof), .LINK_EOF_O(link_eof), .LINK_BYTES_O(link_bytes),
    .CFG_WRITE_I(cfg_wr), .CFG_SA_I(cfg_sa), .CFG_FORMAT_I(fmt), .CFG_BYPASS_I(byp),
    .CFG_KEY_256_I(key), .CFG_FIELD_MASK_I(mask), .LOOKUP_SA_I(lk_sa), .LOOKUP_RX_I(rx),
    .CLASS_FIELDS_O(fields), .SECTAG_OFFSET_O(offset), .CLEAR_BYTES_O(clear), .KEY_256_O(key_o));
  link_mac_model link_mac_model_i (.clk_i(mclk), .rst_n_i(reset_n), .valid_i(link_valid),
    .slow_i(slow), .ready_o(link_ready));
  // ==========================================================================
  // Shared tasks.
  task send(input logic [127:0] d, input logic s, input logic e, input logic [4:0] b,
            input logic f);
    int n;
    core_valid = 1'b1;
    core_data = d;
    core_sof = s;
    core_eof = e;
    core_bytes = b;
    core_fail = f;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (!taken && n < 100);
    if (!taken) fails++;
  endtask
  task expect_w(input logic [63:0] d, input logic [63:0] m, input logic s, input logic e,
                input logic [3:0] b);
    int n;
    logic [69:0] w;
    n = 0;
    while (seen.size() == 0 && n < 100) begin @(posedge mclk); #1; n++; end
    if (seen.size() != 0) w = seen.pop_front();
    else w = 'x;
    `CHK("link word", {s, e, b, d & m}, {w[69:64], w[63:0] & m})
  endtask
  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios.
  task t_frame;
    logic [127:0] a;
    a = 128'h0f0e0d0c0b0a09080706050403020100;
    slow = 1'b1;
    send(a, 1'b1, 1'b0, 5'h10, 1'b0);
    send(~a, 1'b0, 1'b1, 5'h10, 1'b0);
    core_valid = 1'b0;
    expect_w(a[63:0], '1, 1'b1, 1'b0, 4'h8);
    expect_w(a[127:64], '1, 1'b0, 1'b0, 4'h8);
    expect_w(~a[63:0], '1, 1'b0, 1'b0, 4'h8);
    expect_w(~a[127:64], '1, 1'b0, 1'b1, 4'h8);
    slow = 1'b0;
  endtask
  task t_fail;
    logic [127:0] c;
    c = 128'h8899aabbccddeeff0011223344556677;
    send(c, 1'b0, 1'b0, 5'h10, 1'b0);
    send(c, 1'b1, 1'b1, 5'h0c, 1'b1);
    send(~c, 1'b1, 1'b1, 5'h0a, 1'b1);
    send(c, 1'b1, 1'b1, 5'h08, 1'b1);
    core_valid = 1'b0;
    expect_w(c[63:0], '1, 1'b1, 1'b0, 4'h8);
    expect_w({32'h0, code}, 64'hffffffff, 1'b0, 1'b1, 4'h4);
    expect_w(~c[63:0], '1, 1'b1, 1'b0, 4'h8);
    expect_w(~c[127:64], 64'hffff, 1'b0, 1'b1, 4'h2);
    expect_w({code, 32'h0}, 64'hffffffff00000000, 1'b1, 1'b1, 4'h8);
    repeat (4) @(posedge mclk);
    #1 `CHK("extra words", 0, seen.size())
  endtask
  task t_cfg(input logic w, input logic [3:0] sa, input logic [2:0] f, input logic [1:0] b,
             input logic k, input logic [8:0] m, input logic [8:0] etx, input logic [8:0] erx,
             input logic [7:0] ecl);
    cfg_wr = w;
    cfg_sa = sa;
    fmt = f;
    byp = b;
    key = k;
    mask = m;
    lk_sa = sa;
    rx = 1'b0;
    @(posedge mclk);
    #1 cfg_wr = 1'b0;
    repeat (2) @(posedge mclk);
    #1 `CHK("tx fields", etx, fields)
    `CHK("clear bytes", ecl, clear)
    `CHK("tag offset", ecl + 8'h0c, offset)
    `CHK("key length", k, key_o)
    rx = 1'b1;
    repeat (2) @(posedge mclk);
    #1 `CHK("rx fields", erx, fields)
  endtask
  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    repeat (10) @(posedge mclk);
    #1 reset_n = 1'b1;
    t_frame();
    t_fail();
    t_cfg(1'b0, 4'hf, 3'h0, 2'h0, 1'b0, 9'h1ff, 9'h013, 9'h103, 8'h00);
    t_cfg(1'b1, 4'h0, 3'h1, 2'h0, 1'b1, 9'h1ff, 9'h017, 9'h103, 8'h00);
    t_cfg(1'b1, 4'h1, 3'h2, 2'h0, 1'b0, 9'h1ff, 9'h01f, 9'h103, 8'h00);
    t_cfg(1'b1, 4'h2, 3'h1, 2'h1, 1'b1, 9'h1ff, 9'h017, 9'h107, 8'h04);
    t_cfg(1'b1, 4'h3, 3'h2, 2'h1, 1'b0, 9'h1ff, 9'h01f, 9'h107, 8'h04);
    t_cfg(1'b1, 4'h4, 3'h2, 2'h2, 1'b1, 9'h1ff, 9'h01f, 9'h10f, 8'h08);
    t_cfg(1'b1, 4'h5, 3'h3, 2'h3, 1'b0, 9'h1ff, 9'h063, 9'h163, 8'h06);
    t_cfg(1'b1, 4'h6, 3'h4, 2'h3, 1'b1, 9'h1ff, 9'h0e3, 9'h1e3, 8'h0a);
    t_cfg(1'b1, 4'h7, 3'h1, 2'h0, 1'b0, 9'h003, 9'h003, 9'h003, 8'h00);
    t_cfg(1'b0, 4'h0, 3'h1, 2'h0, 1'b1, 9'h1ff, 9'h017, 9'h103, 8'h00);
    end_of_test();
  end
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
endmodule // macsec_output_format_classify_tb_top
bind macsec_output_format_classify macsec_out_chk macsec_out_chk_i (.*);
